/* pirf_pkg.sv */
// Package for the peripheral interrupt flag register block.
// Assumes a single system clock and an APB register port with 32-bit data.
package pirf_pkg;

  // ----------------------------------------------------------------------
  // Register indexes; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [11:0] IDX_SERIAL = 12'hEC8;
  localparam logic [11:0] IDX_TIMER = 12'hEC9;
  localparam logic [11:0] IDX_CELL_GATE = 12'hECA;
  localparam logic [11:0] IDX_CELL_CAPT = 12'hECB;
  localparam logic [11:0] IDX_MEM_WAVE = 12'hECC;
  localparam int NUM_REGS = 5;

  // ----------------------------------------------------------------------
  // Writable masks, reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_SERIAL = 8'h0F;
  localparam logic [7:0] MASK_TIMER = 8'h3F;
  localparam logic [7:0] MASK_CELL_GATE = 8'hF7;
  localparam logic [7:0] MASK_CELL_CAPT = 8'hF3;
  localparam logic [7:0] MASK_MEM_WAVE = 8'hE1;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam int POS_TX1 = 4;
  localparam int POS_RX1 = 5;
  localparam int POS_TX2 = 6;
  localparam int POS_RX2 = 7;
  localparam int POS_CELL_LO = 4;
  localparam int POS_SCAN = 7;
  localparam int POS_CRC = 6;
  localparam int POS_NVM = 5;
  localparam int POS_WAVE = 0;

  typedef enum logic [1:0] {
    PIRF_CAPTURE = 2'h0,
    PIRF_COMPARE = 2'h1,
    PIRF_PWM = 2'h2
  } pirf_ccp_mode_t;

  typedef enum logic [1:0] {
    PIRF_IDLE = 2'b01,
    PIRF_ACCESS = 2'b10
  } pirf_state_t;

  // Event strobes from the peripherals, one cycle each
  typedef struct packed {
    logic [1:0] sync_port_done;
    logic [1:0] sync_port_collision;
    logic [2:0] timer_match;      // timers 2, 4, 6
    logic [2:0] timer_overflow;   // timers 1, 3, 5
    logic [2:0] timer_gate;       // timers 1, 3, 5
    logic [7:0] logic_cell;       // cells 1..8
    logic [1:0] capcomp;          // units 1, 2
    logic memory_scan;
    logic checksum;
    logic nonvolatile;
    logic waveform_gen;
  } pirf_events_t;

  // Buffer status levels from the two asynchronous serial units
  typedef struct packed {
    logic [1:0] uart_rx_full;
    logic [1:0] uart_tx_empty;
  } pirf_uart_status_t;

endpackage : pirf_pkg

/* pirf_flag_regs.sv */
// Five peripheral interrupt flag registers behind an APB slave.
// Assumes event strobes and status levels synchronous to pclk; one clock.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module pirf_flag_regs
  import pirf_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pirf_events_t events,
  input wire pirf_uart_status_t uart_status,
  input wire pirf_ccp_mode_t ccp_mode [2],
  output logic [7:0] flags [NUM_REGS]
);

  if (ADDR_W < 14) begin : g_addr_check
    $error("ADDR_W must be at least 14");
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  localparam logic [11:0] REG_IDX [NUM_REGS] = '{IDX_SERIAL, IDX_TIMER,
    IDX_CELL_GATE, IDX_CELL_CAPT, IDX_MEM_WAVE};
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{MASK_SERIAL, MASK_TIMER,
    MASK_CELL_GATE, MASK_CELL_CAPT, MASK_MEM_WAVE};

  pirf_state_t state;
  logic [NUM_REGS-1:0] hit;
  logic mapped;
  logic wr_commit;
  logic [7:0] rd_byte;

  always_comb begin
    hit = '0;
    rd_byte = 8'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      hit[i] = (paddr[1:0] == 2'h0) &&
               (paddr[ADDR_W-1:2] == (ADDR_W-2)'(REG_IDX[i]));
      if (hit[i]) begin
        rd_byte = flags[i];
      end
    end
  end

  assign mapped = |hit;
  // Writes land only at the completing edge of the access phase
  assign wr_commit = psel && penable && pready && pwrite && mapped && pstrb[0];

  // ----------------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PIRF_IDLE;
    end else begin
      case (state)
        PIRF_IDLE: begin
          if (psel && !penable) begin
            state <= PIRF_ACCESS;
          end
        end
        PIRF_ACCESS: begin
          state <= PIRF_IDLE;
        end
        default: begin
          state <= PIRF_IDLE;
        end
      endcase
    end
  end

  // Read data is captured in setup, so every output stays a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Event set vectors; no enable gating, only capcomp is masked when ccp_mode is PWM
  // ----------------------------------------------------------------------
  logic [7:0] set_vec [NUM_REGS];
  logic [1:0] ccp_fire;

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      ccp_fire[u] = events.capcomp[u] && (ccp_mode[u] != PIRF_PWM);
    end
    set_vec[0] = {4'h0, events.sync_port_collision[1], events.sync_port_done[1],
                  events.sync_port_collision[0], events.sync_port_done[0]};
    set_vec[1] = {2'b00, events.timer_match[2], events.timer_overflow[2],
                  events.timer_match[1], events.timer_overflow[1],
                  events.timer_match[0], events.timer_overflow[0]};
    set_vec[2] = {events.logic_cell[3:0], 1'b0, events.timer_gate};
    set_vec[3] = {events.logic_cell[7:4], 2'b00, ccp_fire};
    set_vec[4] = {events.memory_scan, events.checksum, events.nonvolatile,
                  4'h0, events.waveform_gen};
  end

  // ----------------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        flags[i] <= FLAG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        // Set is ORed after the write so a same-cycle clear loses
        flags[i] <= (((wr_commit && hit[i]) ? pwdata[7:0] : flags[i]) & REG_MASK[i])
                    | (set_vec[i] & REG_MASK[i]);
      end
      // Buffer status bits mirror the serial units; writes never reach them
      flags[0][POS_RX1] <= uart_status.uart_rx_full[0];
      flags[0][POS_RX2] <= uart_status.uart_rx_full[1];
      flags[0][POS_TX1] <= uart_status.uart_tx_empty[0];
      flags[0][POS_TX2] <= uart_status.uart_tx_empty[1];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_write_zero(int r);
    wr_commit && hit[r] && (pwdata[7:0] == 8'h00);
  endsequence

  a_rx_full_mirror: assert property (
    ##1 (flags[0][POS_RX1] == $past(uart_status.uart_rx_full[0])) &&
        (flags[0][POS_RX2] == $past(uart_status.uart_rx_full[1])))
    else $error("receive flag does not follow buffer full");

  a_tx_empty_ro: assert property (
    wr_commit && hit[0] && !uart_status.uart_tx_empty[0] |=> !flags[0][POS_TX1])
    else $error("transmit flag changed by a write");

  a_collision_hold: assert property (
    events.sync_port_collision[0] ##1 (!(wr_commit && hit[0])) [*2] |-> flags[0][1])
    else $error("collision flag not held");

  a_done_set: assert property (
    events.sync_port_done[1] |=> flags[0][2])
    else $error("sync port done flag not set");

  a_match_set: assert property (
    events.timer_match[2] |=> flags[1][5])
    else $error("timer match flag not set");

  a_overflow_set: assert property (
    events.timer_overflow[1] |=> flags[1][2])
    else $error("timer overflow flag not set");

  a_gate_set: assert property (
    events.timer_gate[0] |=> flags[2][0])
    else $error("timer gate flag not set");

  a_cell_upper: assert property (
    events.logic_cell[7] |=> flags[3][7] && flags[3][POS_CELL_LO+3])
    else $error("logic cell flag not set");

  a_capture_set: assert property (
    events.capcomp[0] && ccp_mode[0] == PIRF_CAPTURE |=> flags[3][0])
    else $error("capture flag not set");

  a_pwm_ignored: assert property (
    events.capcomp[1] && ccp_mode[1] == PIRF_PWM && !flags[3][1] &&
    !(wr_commit && hit[3]) |=> !flags[3][1])
    else $error("flag set in pwm mode");

  a_mem_flags: assert property (
    events.memory_scan && events.waveform_gen |=>
      flags[4][POS_SCAN] && flags[4][POS_WAVE])
    else $error("memory or waveform flag not set");

  a_unimpl_zero: assert property (
    flags[4][4:1] == 4'h0 && flags[2][3] == 1'b0 && flags[3][3:2] == 2'b00 &&
    flags[1][7:6] == 2'b00)
    else $error("unimplemented bit reads one");

  a_set_wins: assert property (
    s_write_zero(4) ##0 events.checksum |=> flags[4][POS_CRC])
    else $error("clear won over event");

  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  // ----------------------------------------------------------------------
  // Sticky flags, write path and bus answers
  // ----------------------------------------------------------------------
  // Setup cycle of a transfer
  sequence s_setup;
    psel && !penable;
  endsequence

  // Completing edge of a write to register r
  sequence s_commit(int r);
    wr_commit && hit[r];
  endsequence

  a_tx_empty_mirror: assert property (
    ##1 (flags[0][POS_TX1] == $past(uart_status.uart_tx_empty[0])) &&
        (flags[0][POS_TX2] == $past(uart_status.uart_tx_empty[1])))
    else $error("transmit flag does not follow buffer empty");

  a_rx_full_ro: assert property (
    s_commit(0) ##0 !uart_status.uart_rx_full[1] |=> !flags[0][POS_RX2])
    else $error("receive flag changed by a write");

  a_collision_upper: assert property (
    events.sync_port_collision[1] |=> flags[0][3])
    else $error("upper collision flag not set");

  a_done_hold: assert property (
    events.sync_port_done[0] ##1 (!(wr_commit && hit[0])) [*2] |-> flags[0][0])
    else $error("sync port done flag not held");

  // Without a write, event flag bits can only be gained; register 0 status bits follow their levels
  a_serial_sticky: assert property (
    !(wr_commit && hit[0]) |=> ($past(flags[0][3:0]) & ~flags[0][3:0]) == 4'h0)
    else $error("serial event flag lost without a write");

  a_match_pair: assert property (
    events.timer_match[0] && events.timer_match[1] |=> flags[1][1] && flags[1][3])
    else $error("timer match flags not set");

  a_overflow_pair: assert property (
    events.timer_overflow[0] && events.timer_overflow[2] |=> flags[1][0] && flags[1][4])
    else $error("timer overflow flags not set");

  a_timer_sticky: assert property (
    !(wr_commit && hit[1]) |=> ($past(flags[1]) & ~flags[1]) == 8'h00)
    else $error("timer flag lost without a write");

  a_gate_pair: assert property (
    events.timer_gate[1] && events.timer_gate[2] |=> flags[2][1] && flags[2][2])
    else $error("timer gate flags not set");

  a_cell_lower: assert property (
    events.logic_cell[0] && events.logic_cell[4] |=> flags[2][POS_CELL_LO] && flags[3][POS_CELL_LO])
    else $error("lower logic cell flags not set");

  a_gate_sticky: assert property (
    !(wr_commit && hit[2]) |=> ($past(flags[2]) & ~flags[2]) == 8'h00)
    else $error("gate or cell flag lost without a write");

  a_capture_upper: assert property (
    events.capcomp[1] && ccp_mode[1] == PIRF_CAPTURE |=> flags[3][1])
    else $error("second capture flag not set");

  a_compare_set: assert property (
    events.capcomp[1] && ccp_mode[1] == PIRF_COMPARE |=> flags[3][1])
    else $error("compare flag not set");

  a_capt_sticky: assert property (
    !(wr_commit && hit[3]) |=> ($past(flags[3]) & ~flags[3]) == 8'h00)
    else $error("capture or cell flag lost without a write");

  a_nvm_crc_set: assert property (
    events.nonvolatile && events.checksum |=> flags[4][POS_NVM] && flags[4][POS_CRC])
    else $error("nonvolatile or checksum flag not set");

  a_mem_sticky: assert property (
    !(wr_commit && hit[4]) |=> ($past(flags[4]) & ~flags[4]) == 8'h00)
    else $error("memory or waveform flag lost without a write");

  // Written ones must appear; events may add more
  a_write_lands: assert property (
    s_commit(4) |=> ($past(pwdata[7:0]) & MASK_MEM_WAVE & ~flags[4]) == 8'h00)
    else $error("written flag did not land");

  a_write_clears: assert property (
    s_commit(2) ##0 (pwdata[7:0] == 8'h00) && (events == '0) |=> flags[2] == 8'h00)
    else $error("write of zero did not clear");

  // Read data is the flag value at the setup edge
  a_read_data: assert property (
    s_setup ##0 (!pwrite && hit[4]) |=> prdata == {24'h00_0000, $past(flags[4])})
    else $error("read data differs from flags");

  a_read_upper: assert property (
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");

  // Refused transfers answer with an error and change nothing
  a_refuse_unmapped: assert property (
    s_setup ##0 !mapped |=> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped transfer not refused");

  a_refuse_nowrite: assert property (
    psel && penable && pready && pwrite && !mapped && (events == '0) |=>
      {flags[1], flags[2], flags[3], flags[4]} == $past({flags[1], flags[2], flags[3], flags[4]}))
    else $error("refused write changed a flag");

  a_phase_track: assert property (
    pready |-> state == PIRF_ACCESS)
    else $error("answer outside the access phase");

endmodule // pirf_flag_regs

`default_nettype wire

/* pirf_flag_regs_note_unused.sv */
`timescale 1ns/100ps

/* pirf_periph_model.sv */
// Behavioural stand-in for the peripherals that feed the flag registers.
// Assumes the bench steers it after rising edges of pclk.
`timescale 1ns/100ps
`default_nettype none
module pirf_periph_model
  import pirf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pirf_events_t ev_cmd,
  input wire pirf_uart_status_t st_cmd,
  output var pirf_events_t events,
  output var pirf_uart_status_t uart_status
);
  // ----------------------------------------------------------------------
  // Event strobes, one cycle per request
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events <= '0;
    end else begin
      events <= ev_cmd;
    end
  end

  // ----------------------------------------------------------------------
  // Buffer levels, registered one edge after the bench's status command
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_status <= '0;
    end else begin
      uart_status <= st_cmd;
    end
  end
endmodule // pirf_periph_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench: APB master, peripheral model and a flag model.
// Assumes the package, the flag block and the peripheral model compile first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pirf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] flags [NUM_REGS];
  pirf_events_t ev_cmd = '0;
  pirf_events_t events;
  pirf_uart_status_t st_cmd = '0;
  pirf_uart_status_t uart_status;
  pirf_ccp_mode_t mode [2] = '{PIRF_CAPTURE, PIRF_CAPTURE};
  int errors = 0;
  int compares = 0;
  int ex [NUM_REGS] = '{0, 0, 0, 0, 0};
  logic [31:0] seed = 32'h37;
  logic [7:0] msk [NUM_REGS] = '{MASK_SERIAL, MASK_TIMER, MASK_CELL_GATE, MASK_CELL_CAPT,
    MASK_MEM_WAVE};
  logic [11:0] idx [NUM_REGS] = '{IDX_SERIAL, IDX_TIMER, IDX_CELL_GATE, IDX_CELL_CAPT,
    IDX_MEM_WAVE};

  always #50 pclk = ~pclk;

  pirf_flag_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .events, .uart_status, .ccp_mode(mode), .flags);
  pirf_periph_model peri_u (.pclk, .presetn, .ev_cmd, .st_cmd, .events, .uart_status);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Random strobes, cut to the width of the event carrier
  function automatic pirf_events_t rnd_ev();
    logic [31:0] r;
    r = xs();
    return r[$bits(pirf_events_t)-1:0];
  endfunction

  // Flag bits each event sets, five bytes, register 0 lowest
  function automatic logic [39:0] map_ev(input pirf_events_t e);
    logic [39:0] v;
    v[7:0] = {4'h0, e.sync_port_collision[1], e.sync_port_done[1],
      e.sync_port_collision[0], e.sync_port_done[0]};
    v[15:8] = {2'h0, e.timer_match[2], e.timer_overflow[2], e.timer_match[1],
      e.timer_overflow[1], e.timer_match[0], e.timer_overflow[0]};
    v[23:16] = {e.logic_cell[3:0], 1'b0, e.timer_gate};
    v[31:24] = {e.logic_cell[7:4], 2'h0, e.capcomp[1] & (mode[1] != PIRF_PWM),
      e.capcomp[0] & (mode[0] != PIRF_PWM)};
    v[39:32] = {e.memory_scan, e.checksum, e.nonvolatile, 4'h0, e.waveform_gen};
    return v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Held from setup until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
    input pirf_events_t e, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    ev_cmd <= e;
    @(posedge pclk);
    penable <= 1'b1;
    ev_cmd <= '0;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write with an event fired into the commit cycle
  task automatic wr(input int i, input logic [7:0] d, input pirf_events_t e);
    logic [31:0] rd;
    logic err;
    logic [39:0] v;
    apb(1'b1, {2'b00, idx[i], 2'b00}, d, e, rd, err);
    v = map_ev(e);
    ex[i] = (ex[i] & ~int'(msk[i])) | int'(d & msk[i]);
    for (int k = 0; k < NUM_REGS; k++) ex[k] |= int'(v[8 * k +: 8]);
  endtask

  task automatic check_all();
    logic [31:0] rd;
    logic err;
    logic [7:0] e;
    for (int i = 0; i < NUM_REGS; i++) begin
      apb(1'b0, {2'b00, idx[i], 2'b00}, 8'h00, '0, rd, err);
      e = (i == 0) ? {st_cmd.uart_rx_full[1], st_cmd.uart_tx_empty[1],
        st_cmd.uart_rx_full[0], st_cmd.uart_tx_empty[0], 4'(ex[0])} : 8'(ex[i]);
      chk(rd, {24'h0, e}, "read");
      chk({24'h0, flags[i]}, {24'h0, e}, "flags");
      chk({31'h0, err}, 32'h0, "error");
    end
  endtask

  task automatic final_report();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic err;
    logic [31:0] r;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    check_all();
    apb(1'b0, {2'b00, IDX_MEM_WAVE + 12'h001, 2'b00}, 8'h00, '0, rd, err);
    chk({rd[31:1], err}, 32'h1, "unmapped");
    apb(1'b1, {2'b00, IDX_SERIAL, 2'b01}, 8'hFF, '0, rd, err);
    chk({31'h0, err}, 32'h1, "misaligned");
    check_all();
    // Clear first so stale flags never look like new events
    for (int i = 0; i < NUM_REGS; i++) wr(i, 8'h00, '0);
    for (int n = 0; n < 40; n++) begin
      @(posedge pclk);
      r = xs();
      mode[0] <= pirf_ccp_mode_t'(2'(r % 32'h3));
      mode[1] <= pirf_ccp_mode_t'(2'((r >> 8) % 32'h3));
      st_cmd <= pirf_uart_status_t'(r[19:16]);
      wr(n % NUM_REGS, 8'(xs()), rnd_ev());
      check_all();
      wr((n + 2) % NUM_REGS, (n % 2 == 0) ? 8'hFF : 8'h00, rnd_ev());
    end
    // Reset in mid-run with flags standing; status bits return two edges later
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    for (int i = 0; i < NUM_REGS; i++) chk({24'h0, flags[i]}, 32'h0, "reset");
    @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) ex[i] = 0;
    repeat (2) @(posedge pclk);
    check_all();
    for (int i = 0; i < NUM_REGS; i++) wr(i, 8'h00, '0);
    check_all();
    final_report();
  end

  initial begin
    #(20000 * 100);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
endmodule // testbench
`default_nettype wire
